// ===== rtl/mbic_control.sv
// Bus, restart and exception entry control of an 8-bit processor core.
// Assumes the execution unit signals instruction boundaries and trap/sleep ops.
`timescale 1ns/1ns
`include "mbic_defines.svh"
module mbic_control (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_halt_n,
  input wire logic i_irq_n,
  input wire logic i_nmi_n,
  input wire logic i_bus_float_control,
  input wire logic i_data_drive_enable,
  input wire logic i_insn_done,
  input wire logic i_software_trap_instruction,
  input wire logic i_sleep_until_event_op,
  input wire logic i_core_valid,
  input wire logic i_core_write,
  input wire logic [15:0] i_core_addr,
  input wire logic [7:0] i_core_wdata,
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_value,
  input wire logic i_ccr_load,
  input wire logic [7:0] i_ccr_value,
  input wire logic [15:0] i_x,
  input wire logic [15:0] i_sp,
  input wire logic [7:0] i_acc_a,
  input wire logic [7:0] i_acc_b,
  input wire logic [7:0] i_data_in,
  output logic [15:0] o_addr,
  output logic o_addr_oe,
  output logic o_read_write,
  output logic o_read_write_oe,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_valid_address_strobe,
  output logic o_bus_released,
  output logic [15:0] o_pc,
  output logic [15:0] o_sp,
  output logic [7:0] o_ccr,
  output logic o_core_run
);
  mbic_pkg::mbic_state_t state_q, state_d;
  logic reset_seen_q;
  logic nmi_prev_q;
  logic nmi_pend_q;
  logic [2:0] push_idx_q;
  logic [1:0] cause_q;
  logic [15:0] pc_q;
  logic [15:0] sp_q;
  logic [7:0] ccr_q;
  logic [15:0] addr_q;
  logic [7:0] data_q;
  logic valid_q;
  logic write_q;
  logic [7:0] vec_hi_q;

  // Vector base per entry cause: 0 irq, 1 nmi, 2 trap, 3 restart
  function automatic logic [15:0] mbic_vector(input logic [1:0] cause);
    case (cause)
      2'd0: mbic_vector = `MBIC_VEC_IRQ;
      2'd1: mbic_vector = `MBIC_VEC_NMI;
      2'd2: mbic_vector = `MBIC_VEC_TRAP;
      default: mbic_vector = `MBIC_VEC_RESTART;
    endcase
  endfunction : mbic_vector

  wire mask_set = ccr_q[`MBIC_CCR_MASK_BIT];
  wire halt_req = ~i_halt_n;
  // Interrupts are not taken while halt is asserted; an nmi edge is still latched
  wire irq_ok = ~i_irq_n & ~mask_set & i_halt_n;
  wire nmi_fall = nmi_prev_q & ~i_nmi_n;
  wire nmi_ok = (nmi_pend_q | nmi_fall) & i_halt_n;
  wire at_boundary = (state_q == mbic_pkg::MBIC_RUN) & i_insn_done;
  wire enter_sw = at_boundary & i_software_trap_instruction;
  wire enter_hw = at_boundary & (nmi_ok | irq_ok);
  wire go_sleep = at_boundary & i_sleep_until_event_op & ~enter_hw;
  wire wake = nmi_ok | irq_ok;
  wire [1:0] cause_new = nmi_ok ? 2'd1 : (irq_ok ? 2'd0 : 2'd2);
  wire [1:0] enter_cause = enter_sw ? 2'd2 : cause_new;
  wire [15:0] vec_base = mbic_vector(cause_q);
  wire last_push = (push_idx_q == 3'd6);
  // The byte for the next write is chosen one step ahead of the index, because
  // the entry edge already launches the first push (PC low) from the run state.
  // Selecting on the plain index would write PC low twice and lose the flags.
  wire [2:0] push_sel = (state_q == mbic_pkg::MBIC_STACK) ? push_idx_q + 3'd1 : 3'd0;
  // A pending edge request is consumed when its vector fetch starts, whether
  // the entry came from the run state after stacking or woke the sleep state;
  // an edge that wakes the sleep state in the cycle it falls stays latched.
  // Clearing it anywhere else would either lose an edge or take it twice.
  wire nmi_from_stack = (state_q == mbic_pkg::MBIC_STACK) & last_push & (cause_q == 2'd1);
  wire nmi_from_sleep = (state_q == mbic_pkg::MBIC_SLEEP) & wake & (cause_new == 2'd1);
  wire nmi_taken = nmi_from_stack | nmi_from_sleep;

  // Push byte select, fixed order down the stack
  logic [7:0] push_byte;
  always_comb begin
    case (push_sel)
      3'd0: push_byte = pc_q[7:0];
      3'd1: push_byte = pc_q[15:8];
      3'd2: push_byte = i_x[7:0];
      3'd3: push_byte = i_x[15:8];
      3'd4: push_byte = i_acc_a;
      3'd5: push_byte = i_acc_b;
      default: push_byte = ccr_q | `MBIC_CCR_ONES;
    endcase
  end

  // Sequencer: restart, stacking, vector fetch, sleep and halt.
  // Restart waits one clocked cycle after release before fetching the vector,
  // so the reset value of every register has settled on the bus first.
  // Entries from the run state are only decided at an instruction boundary;
  // the core is never interrupted mid-instruction.
  // Sleep shares the stacking walk with the other entries so that the wake-up
  // only has to fetch a vector, which keeps interrupt latency out of sleep short.
  // Halt is checked last: a hardware request is ignored while halt is low,
  // so the two can never both select a next state in the same cycle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      mbic_pkg::MBIC_RESET: state_d = reset_seen_q ? mbic_pkg::MBIC_VEC_HI : state_q;
      mbic_pkg::MBIC_RUN: begin
        if (enter_hw | enter_sw) begin
          state_d = mbic_pkg::MBIC_STACK;
        end else if (go_sleep) begin
          state_d = mbic_pkg::MBIC_STACK;
        end else if (at_boundary & halt_req) begin
          state_d = mbic_pkg::MBIC_HALTED;
        end
      end
      mbic_pkg::MBIC_STACK: begin
        if (last_push) begin
          state_d = (cause_q == 2'd3) ? mbic_pkg::MBIC_SLEEP : mbic_pkg::MBIC_VEC_HI;
        end
      end
      mbic_pkg::MBIC_SLEEP: state_d = wake ? mbic_pkg::MBIC_VEC_HI : state_q;
      mbic_pkg::MBIC_VEC_HI: state_d = mbic_pkg::MBIC_VEC_LO;
      mbic_pkg::MBIC_VEC_LO: state_d = mbic_pkg::MBIC_RUN;
      mbic_pkg::MBIC_HALTED: state_d = halt_req ? state_q : mbic_pkg::MBIC_RUN;
      default: state_d = mbic_pkg::MBIC_RESET;
    endcase
  end

  // State and request capture; nmi edge latched until taken
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= mbic_pkg::MBIC_RESET;
      reset_seen_q <= 1'b0;
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      reset_seen_q <= 1'b1; // First clocked cycle after release
      nmi_prev_q <= i_nmi_n;
      // A new edge wins over the clear of the same cycle
      nmi_pend_q <= nmi_fall | (nmi_pend_q & ~nmi_taken);
    end
  end

  // Entry cause and stack walk; sleep stacks first then waits (cause 3 marks sleep).
  // The index counts the pushes launched after the first; the walk ends after the seventh.
  // Cause 3 doubles as the restart cause out of reset, which the vector
  // function maps onto the restart vector pair.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cause_q <= 2'd3;
      push_idx_q <= 3'd0;
    end else if (state_q == mbic_pkg::MBIC_RUN) begin
      push_idx_q <= 3'd0;
      cause_q <= (go_sleep & ~enter_sw) ? 2'd3 : enter_cause;
    end else if (state_q == mbic_pkg::MBIC_STACK) begin
      push_idx_q <= push_idx_q + 3'd1;
    end else if (state_q == mbic_pkg::MBIC_SLEEP && wake) begin
      cause_q <= cause_new;
    end
  end

  // Programmer registers owned here: program counter, stack pointer, flags
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pc_q <= 16'h0000;
      sp_q <= `MBIC_SP_RESET;
      ccr_q <= `MBIC_CCR_RESET; // Mask set by restart
      vec_hi_q <= 8'h00;
    end else begin
      if (state_q == mbic_pkg::MBIC_VEC_HI) begin
        vec_hi_q <= i_data_in;
      end
      if (state_q == mbic_pkg::MBIC_VEC_LO) begin
        pc_q <= {vec_hi_q, i_data_in};
      end else if (i_pc_load && state_q == mbic_pkg::MBIC_RUN) begin
        pc_q <= i_pc_value;
      end
      // Take the core's pointer at every boundary, entries included, so the
      // stacking walk decrements from the value the first push used
      if (state_q == mbic_pkg::MBIC_RUN && i_insn_done) begin
        sp_q <= i_sp;
      end else if (state_q == mbic_pkg::MBIC_STACK) begin
        sp_q <= sp_q - 16'h0001;
      end
      if (state_q == mbic_pkg::MBIC_VEC_LO && cause_q != 2'd1) begin
        ccr_q <= ccr_q | 8'h10 | `MBIC_CCR_ONES;
      end else if (state_q == mbic_pkg::MBIC_VEC_LO) begin
        ccr_q <= ccr_q | 8'h10 | `MBIC_CCR_ONES;
      end else if (i_ccr_load && state_q == mbic_pkg::MBIC_RUN) begin
        ccr_q <= i_ccr_value | `MBIC_CCR_ONES;
      end
    end
  end

  // Bus cycle registers; reset drives vector-like all-ones upper address.
  // Keyed on the next state so every bus cycle appears one clock after the
  // decision and then stands for exactly one clock.
  // The stack address of the first push comes straight from the core, the
  // later ones from the local pointer that is being walked down.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      addr_q <= `MBIC_ADDR_RESET;
      data_q <= 8'h00;
      valid_q <= 1'b0;
      write_q <= 1'b0;
    end else begin
      case (state_d)
        mbic_pkg::MBIC_VEC_HI: begin
          addr_q <= (state_q == mbic_pkg::MBIC_RESET) ? `MBIC_VEC_RESTART :
                    mbic_vector((state_q == mbic_pkg::MBIC_SLEEP) ? cause_new : cause_q);
          valid_q <= 1'b1;
          write_q <= 1'b0;
        end
        mbic_pkg::MBIC_VEC_LO: begin
          addr_q <= vec_base | 16'h0001;
          valid_q <= 1'b1;
          write_q <= 1'b0;
        end
        mbic_pkg::MBIC_STACK: begin
          addr_q <= (state_q == mbic_pkg::MBIC_STACK) ? sp_q - 16'h0001 : i_sp;
          data_q <= push_byte;
          valid_q <= 1'b1;
          write_q <= 1'b1;
        end
        mbic_pkg::MBIC_RUN: begin
          addr_q <= i_core_addr;
          data_q <= i_core_wdata;
          valid_q <= i_core_valid;
          write_q <= i_core_valid & i_core_write;
        end
        default: begin
          addr_q <= (state_d == mbic_pkg::MBIC_RESET) ? `MBIC_ADDR_RESET : addr_q;
          valid_q <= 1'b0;
          write_q <= 1'b0;
        end
      endcase
    end
  end

  // Stopped states release the bus; bus-float overrides everything but data.
  // These gates are combinational on purpose: a DMA master expects the
  // address and read/write drivers off in the same cycle it raises float.
  // The strobe is never floated, only forced low, so peripherals always see
  // a defined qualifier even when another master owns the address lines.
  // Limitation: the dynamic-state time limit on float is the master's duty.
  wire stopped = (state_q == mbic_pkg::MBIC_HALTED) | (state_q == mbic_pkg::MBIC_SLEEP);
  assign o_addr = addr_q;
  assign o_addr_oe = ~i_bus_float_control & ~stopped;
  assign o_read_write = ~write_q; // Idles high
  assign o_read_write_oe = ~i_bus_float_control & ~stopped;
  assign o_data = data_q;
  assign o_data_oe = i_data_drive_enable & write_q & ~stopped;
  assign o_valid_address_strobe = valid_q & ~i_bus_float_control & ~stopped;
  assign o_bus_released = stopped & ~i_bus_float_control;
  assign o_pc = pc_q;
  assign o_sp = sp_q;
  assign o_ccr = ccr_q | `MBIC_CCR_ONES;
  assign o_core_run = (state_q == mbic_pkg::MBIC_RUN);
endmodule : mbic_control

// ===== rtl/mbic_defines.svh
// Constants for the bus and exception control block: vectors, flag bits, reset values.
// Assumes a single 100 MHz clock; included by bare name.
`ifndef MBIC_DEFINES_SVH
`define MBIC_DEFINES_SVH
`define MBIC_VEC_RESTART 16'hFFFE
`define MBIC_VEC_NMI 16'hFFFC
`define MBIC_VEC_TRAP 16'hFFFA
`define MBIC_VEC_IRQ 16'hFFF8
`define MBIC_CCR_MASK_BIT 4
`define MBIC_CCR_ONES 8'hC0
`define MBIC_CCR_RESET 8'hD0
`define MBIC_SP_RESET 16'h0000
`define MBIC_ADDR_RESET 16'hFF00
`endif

// ===== rtl/mbic_pkg.sv
// Types for the bus and exception control block.
// Assumes the defines header is compiled alongside.
package mbic_pkg;
  typedef enum logic [3:0] {
    MBIC_RESET = 4'h0,
    MBIC_RUN = 4'h1,
    MBIC_STACK = 4'h3,
    MBIC_VEC_HI = 4'h2,
    MBIC_VEC_LO = 4'h6,
    MBIC_SLEEP = 4'h7,
    MBIC_HALTED = 4'h5
  } mbic_state_t;
endpackage : mbic_pkg

// ===== tb/mbic_control_asserts.sv
// Checker for the bus and exception control block.
// Sees only the ports of mbic_control; bound after the module.
`timescale 1ns/1ns
module mbic_control_asserts (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_halt_n,
  input wire logic i_irq_n,
  input wire logic i_nmi_n,
  input wire logic i_bus_float_control,
  input wire logic i_data_drive_enable,
  input wire logic i_insn_done,
  input wire logic i_software_trap_instruction,
  input wire logic i_sleep_until_event_op,
  input wire logic [15:0] o_addr,
  input wire logic o_addr_oe,
  input wire logic o_read_write,
  input wire logic o_read_write_oe,
  input wire logic o_data_oe,
  input wire logic o_valid_address_strobe,
  input wire logic o_bus_released,
  input wire logic [7:0] o_ccr,
  input wire logic o_core_run
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Qualified write cycle on the bus
  wire wr_cyc = o_valid_address_strobe && !o_read_write;
  // Entry steps: seven pushes, then the maskable vector pair
  sequence push_seq;
    wr_cyc [*7];
  endsequence
  sequence irq_vec_seq;
    o_addr == 16'hFFF8 ##1 o_addr == 16'hFFF9;
  endsequence
  reset_upper_a: assert property ($rose(i_reset_n) |-> o_addr[15:8] == 8'hFF)
    else $error("upper address not high at restart");
  restart_vec_a: assert property ($rose(i_reset_n) |-> ##2 o_addr == 16'hFFFE ##1 o_addr == 16'hFFFF)
    else $error("restart vector fetch out of place");
  mask_reset_a: assert property ($rose(i_reset_n) |-> ##2 o_ccr[4])
    else $error("mask clear after restart");
  ccr_ones_a: assert property (o_ccr[7:6] == 2'b11)
    else $error("flag bits 7:6 not ones");
  irq_entry_a: assert property (o_core_run && i_insn_done && !i_irq_n && !o_ccr[4] && i_halt_n
    && i_nmi_n && !i_software_trap_instruction && !i_sleep_until_event_op
    && !i_bus_float_control |=> push_seq ##1 irq_vec_seq)
    else $error("maskable entry sequence wrong");
  float_off_a: assert property (i_bus_float_control |-> !o_addr_oe && !o_read_write_oe
    && !o_valid_address_strobe && !o_bus_released)
    else $error("bus not floated");
  data_drive_a: assert property (o_data_oe |-> i_data_drive_enable && !o_read_write)
    else $error("data driven outside a permitted write");
  released_a: assert property (o_bus_released |-> !o_valid_address_strobe && !o_addr_oe
    && !o_read_write_oe && !o_data_oe)
    else $error("outputs active while released");
  push_dec_a: assert property (wr_cyc ##1 wr_cyc |-> o_addr == $past(o_addr) - 16'h0001)
    else $error("stack address not decrementing");
  vec_pair_a: assert property (o_valid_address_strobe && o_read_write && o_addr[15:3] == 13'h1FFF
    && !o_addr[0] |=> o_addr == $past(o_addr) + 16'h0001)
    else $error("vector low byte not next");
  halt_rel_a: assert property (!i_halt_n && o_core_run && i_insn_done |-> ##[1:3] o_bus_released)
    else $error("halt did not release bus");
endmodule : mbic_control_asserts
bind mbic_control mbic_control_asserts u_mbic_control_asserts (.*);

// ===== tb/mbic_mem_model.sv
// Memory on the far side: read data is a fixed function of the address.
// Assumes select is strobe qualified by the address drivers being on.
`timescale 1ns/1ns
module mbic_mem_model (
  input wire logic i_clk,
  input wire logic [15:0] i_addr,
  input wire logic i_sel,
  input wire logic i_read,
  output logic [7:0] o_rdata
);
  logic [7:0] last_q = 8'h00;
  // Deselected, the bus shows a changing pattern so stale data never matches
  assign o_rdata = (i_sel && i_read) ? (i_addr[7:0] ^ 8'hA5) : ~last_q;
  always @(posedge i_clk) last_q <= o_rdata;
endmodule : mbic_mem_model

// ===== tb/tb_top.sv
// Testbench for mbic_control: restart, entries, halt, sleep and bus float.
// Assumes the memory model answers every read in the same cycle.
`timescale 1ns/1ns
module tb_top;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_halt_n = 1'b1, i_irq_n = 1'b1, i_nmi_n = 1'b1;
  logic i_bus_float_control = 1'b0, i_data_drive_enable = 1'b1, i_insn_done = 1'b0;
  logic i_software_trap_instruction = 1'b0, i_sleep_until_event_op = 1'b0;
  logic i_core_valid = 1'b0, i_core_write = 1'b0, i_pc_load = 1'b0, i_ccr_load = 1'b0;
  logic [15:0] i_core_addr = 16'h0000, i_pc_value = 16'h0000;
  logic [7:0] i_core_wdata = 8'h00, i_ccr_value = 8'hC0, i_data_in;
  logic [15:0] o_addr, o_pc, o_sp;
  logic [7:0] o_data, o_ccr;
  logic o_addr_oe, o_read_write, o_read_write_oe, o_data_oe;
  logic o_valid_address_strobe, o_bus_released, o_core_run;
  int bad_count = 0, samples_checked = 0;
  always #5 i_clk = ~i_clk;
  mbic_control u_mbic_control (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_halt_n(i_halt_n),
    .i_irq_n(i_irq_n), .i_nmi_n(i_nmi_n), .i_bus_float_control(i_bus_float_control),
    .i_data_drive_enable(i_data_drive_enable), .i_insn_done(i_insn_done),
    .i_software_trap_instruction(i_software_trap_instruction),
    .i_sleep_until_event_op(i_sleep_until_event_op), .i_core_valid(i_core_valid),
    .i_core_write(i_core_write), .i_core_addr(i_core_addr), .i_core_wdata(i_core_wdata),
    .i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .i_ccr_load(i_ccr_load),
    .i_ccr_value(i_ccr_value), .i_x(16'h1357), .i_sp(16'h01FF), .i_acc_a(8'h11),
    .i_acc_b(8'h22), .i_data_in(i_data_in), .o_addr(o_addr), .o_addr_oe(o_addr_oe),
    .o_read_write(o_read_write), .o_read_write_oe(o_read_write_oe), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_valid_address_strobe(o_valid_address_strobe),
    .o_bus_released(o_bus_released), .o_pc(o_pc), .o_sp(o_sp), .o_ccr(o_ccr),
    .o_core_run(o_core_run));
  mbic_mem_model u_mbic_mem_model (.i_clk(i_clk), .i_addr(o_addr),
    .i_sel(o_valid_address_strobe & o_addr_oe), .i_read(o_read_write), .o_rdata(i_data_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic wait_run();
    int k;
    k = 0;
    while (o_core_run !== 1'b1 && k < 60) begin
      tick(1);
      k++;
    end
    if (k >= 60) bad_count++;
  endtask : wait_run
  // One instruction end, optionally a trap or sleep op
  task automatic enter(input logic tr, input logic sl);
    i_insn_done = 1'b1;
    i_software_trap_instruction = tr;
    i_sleep_until_event_op = sl;
    tick(1);
    i_insn_done = 1'b0;
    i_software_trap_instruction = 1'b0;
    i_sleep_until_event_op = 1'b0;
    tick(1);
  endtask : enter
  function automatic logic [15:0] vecv(input logic [15:0] v);
    return {v[7:0] ^ 8'hA5, (v[7:0] + 8'h01) ^ 8'hA5};
  endfunction : vecv
  task automatic unmask();
    i_ccr_load = 1'b1;
    tick(1);
    i_ccr_load = 1'b0;
  endtask : unmask
  task automatic finish_test();
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic do_reset();
    i_reset_n = 1'b0;
    tick(8);
    i_reset_n = 1'b1;
    tick(1);
    wait_run();
    chk(o_pc, vecv(16'hFFFE));
    chk({15'h0, o_ccr[4]}, 16'h0001);
  endtask : do_reset
  task automatic t_write();
    i_core_valid = 1'b1;
    i_core_write = 1'b1;
    i_core_addr = 16'h1234;
    i_core_wdata = 8'h3C;
    tick(1);
    i_core_valid = 1'b0;
    chk(o_addr, 16'h1234);
    chk({6'h00, o_data_oe, o_read_write, o_data}, 16'h023C);
    i_data_drive_enable = 1'b0;
    #1;
    chk({15'h0, o_data_oe}, 16'h0000);
    i_data_drive_enable = 1'b1;
  endtask : t_write
  task automatic t_irq();
    i_irq_n = 1'b0;
    enter(1'b0, 1'b0);
    chk({15'h0, o_core_run}, 16'h0001);
    unmask();
    enter(1'b0, 1'b0);
    i_irq_n = 1'b1;
    wait_run();
    chk(o_pc, vecv(16'hFFF8));
    chk({15'h0, o_ccr[4]}, 16'h0001);
    chk(o_sp, 16'h01F8);
  endtask : t_irq
  task automatic t_nmi_trap();
    i_nmi_n = 1'b0;
    tick(1);
    enter(1'b0, 1'b0);
    wait_run();
    chk(o_pc, vecv(16'hFFFC));
    i_nmi_n = 1'b1;
    tick(1);
    enter(1'b1, 1'b0);
    wait_run();
    chk(o_pc, vecv(16'hFFFA));
  endtask : t_nmi_trap
  task automatic t_halt_sleep();
    unmask();
    i_halt_n = 1'b0;
    i_irq_n = 1'b0;
    enter(1'b0, 1'b0);
    tick(2);
    chk({14'h0, o_bus_released, o_valid_address_strobe}, 16'h0002);
    i_irq_n = 1'b1;
    tick(1);
    i_halt_n = 1'b1;
    tick(1);
    wait_run();
    chk(o_pc, vecv(16'hFFFA));
    enter(1'b0, 1'b1);
    tick(10);
    chk({15'h0, o_bus_released}, 16'h0001);
    i_irq_n = 1'b0;
    tick(1);
    wait_run();
    i_irq_n = 1'b1;
    chk(o_pc, vecv(16'hFFF8));
    i_bus_float_control = 1'b1; // Held one cycle, far below the limit
    #1;
    chk({o_addr_oe, o_read_write_oe, o_valid_address_strobe, o_bus_released}, 16'h0000);
    tick(1);
    i_bus_float_control = 1'b0;
  endtask : t_halt_sleep
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
  initial begin
    tick(1);
    do_reset();
    t_write();
    t_irq();
    t_nmi_trap();
    t_halt_sleep();
    do_reset();
    finish_test();
  end
endmodule : tb_top
